//--- verilog/system_options_system_ctrl.v
/*
 System options, device identification and periodic wakeup control with an
 AHB-Lite register slave. Assumes hclk at 100 MHz, tick inputs already
 synchronous to hclk as one-cycle pulses, and strap levels stable at reset.
 Writes complete with no wait state; every read inserts exactly one, so
 that hrdata comes straight from a flip-flop. Responses are always OKAY.
*/
// Overview of operation
// - Watchdog enable bit, written once only
// - Watchdog timeout select short or long, once
// - Stop disabled turns stop into illegal reset
// - Options honour first write, ignore later ones
// - Debug pin enable routes shared pin
// - Debug enable resets per mode, security and power-on reset
// - Debug enable only clears, never sets
// - Reset pin enable gives reset and pullup
// - Reset pin starts as input port
// - Revision nibble hard-wired read-only
// - Twelve-bit part number hard-wired read-only
// - Wakeup flag set on timeout, read-only
// - Acknowledge write one clears, reads zero
// - Clock select: 1 kHz or 32 kHz/32
// - Period code zero disables, else table
// - Interrupt needs enable and flag
`timescale 1ns/1ps
`default_nettype none
`include "system_options_map.vh"

module system_options_system_ctrl
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        power_on_reset,
  input  wire        mode_select_pin,
  input  wire        security_disengaged,
  input  wire        stop_request,
  input  wire        tick_1khz,
  input  wire        tick_32khz,
  output wire        watchdog_enable,
  output wire        watchdog_timeout_select,
  output wire        stop_mode_enable,
  output wire        stop_enter,
  output reg         illegal_opcode_reset,
  output wire        debug_pin_enable,
  output wire        reset_pin_enable,
  output wire        reset_pin_pullup,
  output wire        wakeup_irq,
  output wire        irq
);

  // Wakeup period lookup, code zero gives zero (disabled)
  function [10:0] period_of;
    input [2:0] code;
    begin
      case (code)
        3'h1:    period_of = `SYSTEM_OPTIONS_PER_1;
        3'h2:    period_of = `SYSTEM_OPTIONS_PER_2;
        3'h3:    period_of = `SYSTEM_OPTIONS_PER_3;
        3'h4:    period_of = `SYSTEM_OPTIONS_PER_4;
        3'h5:    period_of = `SYSTEM_OPTIONS_PER_5;
        3'h6:    period_of = `SYSTEM_OPTIONS_PER_6;
        3'h7:    period_of = `SYSTEM_OPTIONS_PER_7;
        default: period_of = 11'h000;
      endcase
    end
  endfunction

  // Bus data phase bookkeeping
  reg        wr_pend_reg;    // Write data phase pending
  reg        rd_pend_reg;    // Read data phase pending
  reg  [7:0] addr_reg;       // Latched word address
  reg        rd_ready_reg;   // Second cycle of a read data phase
  // Option bits
  reg        wdog_en_reg;    // Watchdog enable
  reg        wdog_long_reg;  // Watchdog long timeout
  reg        stop_en_reg;    // Stop permitted
  reg        dbg_pin_reg;    // Debug pin routing
  reg        rst_pin_reg;    // Reset pin function
  reg        written_reg;    // First write already taken
  reg        strap_done_reg; // Debug reset value captured
  // Wakeup logic
  reg        wk_flag_reg;    // Wakeup flag
  reg        wk_clksel_reg;  // Clock source select
  reg        wk_irqen_reg;   // Wakeup interrupt enable
  reg  [2:0] wk_per_reg;     // Period code
  reg  [4:0] div_reg;        // Divide-by-32 prescaler
  reg [10:0] wk_cnt_reg;     // Tick counter
  // Interrupt block
  reg  [1:0] irq_stat_reg;   // Sticky events
  reg  [1:0] irq_en_reg;     // Event enables

  // Decoded bus strobes and the wakeup tick path
  wire       addr_ok;        // Address phase valid this cycle
  wire       wr_opt;         // Write to options
  wire       wr_wk;          // Write to wakeup register
  wire       tick;           // Selected 1 ms tick
  wire       timeout;        // Wakeup period reached
  wire [10:0] period;        // Current period length
  wire [1:0] events;         // Events this cycle
  wire [7:0] wdat;           // Written byte
  reg  [7:0] rd_byte;        // Read mux

  // Slave answer: writes need no wait, a read holds hreadyout low for one
  // cycle so that hrdata can be loaded from a flip-flop before it is taken
  assign hreadyout = ~rd_pend_reg | rd_ready_reg;
  // Nothing in this block can fail a transfer
  assign hresp     = 1'b0;
  // A transfer is taken only while the previous data phase finishes
  assign addr_ok   = hsel & hready & htrans[1];
  // Registers are eight bits wide and sit in the low byte lane
  assign wdat      = hwdata[7:0];
  // Write strobes fire in the data phase, when hwdata is on the bus
  assign wr_opt    = wr_pend_reg & (addr_reg == `SYSTEM_OPTIONS_OFS_OPTIONS);
  assign wr_wk     = wr_pend_reg & (addr_reg == `SYSTEM_OPTIONS_OFS_WAKEUP);

  // Capture address phase; the pending flags mark the data phase after it
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // Reset: no transfer in flight
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end
    // Advance only when the current data phase finishes
    else if (hready)
    begin
      wr_pend_reg <= addr_ok & hwrite;
      rd_pend_reg <= addr_ok & ~hwrite;
      // Keep the word address; byte lanes are not decoded
      if (addr_ok)
        addr_reg <= {haddr[7:2], 2'b00};
    end
  end

  // Read wait state: the first cycle of a read data phase loads hrdata and
  // holds hreadyout low, the second one completes the transfer. The toggle
  // also spaces back-to-back reads, each one gets its own wait state.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      // Reset: no read in flight
      rd_ready_reg <= 1'b0;
    else
      // High for exactly the second cycle of each read data phase
      rd_ready_reg <= rd_pend_reg & ~rd_ready_reg;
  end

  // Option register, one write after reset
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // Reset: chosen option defaults, debug pin on its debug role
      wdog_en_reg    <= `SYSTEM_OPTIONS_RST_WDOG_EN;
      wdog_long_reg  <= `SYSTEM_OPTIONS_RST_WDOG_LONG;
      stop_en_reg    <= `SYSTEM_OPTIONS_RST_STOP_EN;
      rst_pin_reg    <= `SYSTEM_OPTIONS_RST_RST_PIN;
      dbg_pin_reg    <= 1'b1;
      // Write-once lock and strap capture both rearm on every reset
      written_reg    <= 1'b0;
      strap_done_reg <= 1'b0;
    end
    else
    begin
      // Straps are looked at once only, on the first edge after release
      // strap caught after release
      if (!strap_done_reg)
      begin
        strap_done_reg <= 1'b1;
        dbg_pin_reg    <= ~mode_select_pin | security_disengaged | power_on_reset;
      end
      // Later writes fall through here and only raise an event below
      // first write only
      if (wr_opt & ~written_reg)
      begin
        written_reg   <= 1'b1;
        wdog_en_reg   <= wdat[`SYSTEM_OPTIONS_BIT_WDOG_EN];
        wdog_long_reg <= wdat[`SYSTEM_OPTIONS_BIT_WDOG_LONG];
        // Stop permission and pin role share the single write
        stop_en_reg   <= wdat[`SYSTEM_OPTIONS_BIT_STOP_EN];
        rst_pin_reg   <= wdat[`SYSTEM_OPTIONS_BIT_RST_PIN];
        // Until the strap is in, a write must not override its value
        // only one-to-zero accepted
        if (strap_done_reg)
          dbg_pin_reg <= dbg_pin_reg & wdat[`SYSTEM_OPTIONS_BIT_DBG_PIN];
      end
    end
  end

  // Option levels go straight to the watchdog, stop and pin logic
  assign watchdog_enable         = wdog_en_reg;
  assign watchdog_timeout_select = wdog_long_reg;
  assign stop_mode_enable        = stop_en_reg;
  assign debug_pin_enable        = dbg_pin_reg;
  assign reset_pin_enable        = rst_pin_reg;
  assign reset_pin_pullup        = rst_pin_reg;
  // Combinational, so the core sees the answer in the same cycle
  // stop only when permitted
  assign stop_enter              = stop_request & stop_en_reg;

  // Registered so the reset request never glitches on the stop decode
  // illegal-opcode reset pulse
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      // Reset: no request pending
      illegal_opcode_reset <= 1'b0;
    else
      // Stop while disabled asks for a reset one cycle later
      illegal_opcode_reset <= stop_request & ~stop_en_reg;
  end

  // The fast source is divided by 32 to give its own 1 ms tick
  // clock source and prescaler
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      // Reset: prescaler cleared
      div_reg <= 5'h00;
    else if (!wk_clksel_reg)
      // Slow source selected: keep the prescaler at zero
      div_reg <= 5'h00;
    else if (tick_32khz)
      // Count fast pulses, wrapping every 32
      div_reg <= div_reg + 5'h01;
  end

  // Selected tick: last fast pulse of each group of 32, or the slow pulse
  assign tick    = wk_clksel_reg ? (tick_32khz & (div_reg == 5'h1f)) : tick_1khz;
  assign period  = period_of(wk_per_reg);
  // Timeout on the tick that completes the period; code zero never times
  // out. Greater-or-equal so a shorter period written mid-count cannot
  // leave the counter beyond its end until it wraps.
  assign timeout = tick & (period != 11'h000) & (wk_cnt_reg >= period - 11'd1);

  // count ticks, restart, clear when disabled
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      // Reset: counter cleared
      wk_cnt_reg <= 11'h000;
    else if (period == 11'h000)
      // Disabled: held cleared so a new period starts from zero
      wk_cnt_reg <= 11'h000;
    else if (timeout)
      // Period reached: restart
      wk_cnt_reg <= 11'h000;
    else if (tick)
      // One more tick of the selected source
      wk_cnt_reg <= wk_cnt_reg + 11'd1;
  end

  // Wakeup control and flag
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // Reset: wakeup disabled, flag clear, slow source
      wk_flag_reg   <= 1'b0;
      wk_clksel_reg <= 1'b0;
      wk_irqen_reg  <= 1'b0;
      wk_per_reg    <= 3'h0;
    end
    else
    begin
      // Control fields written in the data phase of a write
      if (wr_wk)
      begin
        wk_clksel_reg <= wdat[`SYSTEM_OPTIONS_BIT_WK_CLKSEL];
        wk_irqen_reg  <= wdat[`SYSTEM_OPTIONS_BIT_WK_IRQEN];
        wk_per_reg    <= wdat[`SYSTEM_OPTIONS_WK_PER_MSB:0];
      end
      // set on timeout, wins over ack
      if (timeout)
        wk_flag_reg <= 1'b1;
      else if (wr_wk & wdat[`SYSTEM_OPTIONS_BIT_WK_ACK])
        wk_flag_reg <= 1'b0;
    end
  end

  assign wakeup_irq = wk_flag_reg & wk_irqen_reg;

  // Sticky events: wakeup timeout, ignored option write
  assign events = {wr_opt & written_reg, timeout};

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // Reset: no events recorded, every source masked
      irq_stat_reg <= 2'b00;
      irq_en_reg   <= 2'b00;
    end
    else
    begin
      // Enable register is plain read-write
      if (wr_pend_reg & (addr_reg == `SYSTEM_OPTIONS_OFS_IRQ_ENABLE))
        irq_en_reg <= wdat[1:0];
      // Set wins over clear
      if (wr_pend_reg & (addr_reg == `SYSTEM_OPTIONS_OFS_IRQ_CLEAR))
        irq_stat_reg <= (irq_stat_reg & ~wdat[1:0]) | events;
      else
        irq_stat_reg <= irq_stat_reg | events;
    end
  end

  // One level output while any enabled status bit is set
  assign irq = |(irq_stat_reg & irq_en_reg);

  // Read mux
  always @*
  begin
    // Decode the word latched in the address phase
    case (addr_reg)
      `SYSTEM_OPTIONS_OFS_OPTIONS:
        rd_byte = {wdog_en_reg, wdog_long_reg, stop_en_reg, 3'b000,
                   dbg_pin_reg, rst_pin_reg};
      `SYSTEM_OPTIONS_OFS_IDENT_HIGH:
        rd_byte = {`SYSTEM_OPTIONS_REVISION, `SYSTEM_OPTIONS_PART_NUMBER_HI};
      `SYSTEM_OPTIONS_OFS_IDENT_LOW:
        rd_byte = `SYSTEM_OPTIONS_PART_NUMBER_LO;
      `SYSTEM_OPTIONS_OFS_WAKEUP:
        rd_byte = {wk_flag_reg, 1'b0, wk_clksel_reg, wk_irqen_reg, 1'b0, wk_per_reg};
      // Interrupt status and enable, upper bits zero
      `SYSTEM_OPTIONS_OFS_IRQ_STATUS:
        rd_byte = {6'h00, irq_stat_reg};
      `SYSTEM_OPTIONS_OFS_IRQ_ENABLE:
        rd_byte = {6'h00, irq_en_reg};
      // Unmapped words and the write-only clear word read zero
      default:
        rd_byte = 8'h00;
    endcase
  end

  // Read data register: loaded in the wait cycle of a read so it stands for
  // the whole completing cycle, cleared when the next read is taken
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      // Reset: bus reads zero
      hrdata <= 32'h00000000;
    else if (rd_pend_reg & ~rd_ready_reg)
      // First data-phase cycle: register byte into the low lane
      hrdata <= {24'h000000, rd_byte};
    else if (addr_ok & ~hwrite)
      // New read accepted: drop the stale word
      hrdata <= 32'h00000000;
  end

endmodule
`default_nettype wire

//--- verilog/system_options_map.vh
/*
 System control block constants: register byte offsets, field positions,
 reset values and wakeup periods. Assumes a 32-bit AHB-Lite slave with one
 register per aligned word, 8-bit registers in the low byte.
*/
`ifndef SYSTEM_OPTIONS_MAP_VH
`define SYSTEM_OPTIONS_MAP_VH

// Register byte offsets
`define SYSTEM_OPTIONS_OFS_OPTIONS     8'h00
`define SYSTEM_OPTIONS_OFS_IDENT_HIGH  8'h04
`define SYSTEM_OPTIONS_OFS_IDENT_LOW   8'h08
`define SYSTEM_OPTIONS_OFS_WAKEUP      8'h0c
`define SYSTEM_OPTIONS_OFS_IRQ_STATUS  8'h10
`define SYSTEM_OPTIONS_OFS_IRQ_ENABLE  8'h14
`define SYSTEM_OPTIONS_OFS_IRQ_CLEAR   8'h18

// System options field positions
`define SYSTEM_OPTIONS_BIT_WDOG_EN     7
`define SYSTEM_OPTIONS_BIT_WDOG_LONG   6
`define SYSTEM_OPTIONS_BIT_STOP_EN     5
`define SYSTEM_OPTIONS_BIT_DBG_PIN     1
`define SYSTEM_OPTIONS_BIT_RST_PIN     0

// Wakeup status/control field positions
`define SYSTEM_OPTIONS_BIT_WK_FLAG     7
`define SYSTEM_OPTIONS_BIT_WK_ACK      6
`define SYSTEM_OPTIONS_BIT_WK_CLKSEL   5
`define SYSTEM_OPTIONS_BIT_WK_IRQEN    4
`define SYSTEM_OPTIONS_WK_PER_MSB      2

// Interrupt status bits
`define SYSTEM_OPTIONS_IRQ_WAKEUP      0
`define SYSTEM_OPTIONS_IRQ_WR_IGNORED  1

// Reset values of the plain option bits
`define SYSTEM_OPTIONS_RST_WDOG_EN     1'b1
`define SYSTEM_OPTIONS_RST_WDOG_LONG   1'b1
`define SYSTEM_OPTIONS_RST_STOP_EN     1'b0
`define SYSTEM_OPTIONS_RST_RST_PIN     1'b0

// Identification: revision and part number, arbitrary neutral values
`define SYSTEM_OPTIONS_REVISION        4'h1
`define SYSTEM_OPTIONS_PART_NUMBER     12'h5a3
// Part number split across the two identification words, also arbitrary
`define SYSTEM_OPTIONS_PART_NUMBER_HI  4'h5
`define SYSTEM_OPTIONS_PART_NUMBER_LO  8'ha3

// Tick source: 1 ms tick, 32 kHz divided by 32
`define SYSTEM_OPTIONS_TICK_MS         1
`define SYSTEM_OPTIONS_FAST_DIV        32

// Wakeup periods in ticks
`define SYSTEM_OPTIONS_PER_1           11'd8
`define SYSTEM_OPTIONS_PER_2           11'd32
`define SYSTEM_OPTIONS_PER_3           11'd64
`define SYSTEM_OPTIONS_PER_4           11'd128
`define SYSTEM_OPTIONS_PER_5           11'd256
`define SYSTEM_OPTIONS_PER_6           11'd512
`define SYSTEM_OPTIONS_PER_7           11'd1024

`endif

//--- bench/system_options_system_ctrl_sva.sv
/*
 Checker for the system control block.
 Assumes it is bound to the ports of system_options_system_ctrl.
*/
`timescale 1ns/1ps
`default_nettype none
module system_options_system_ctrl_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        power_on_reset,
  input wire logic        mode_select_pin,
  input wire logic        security_disengaged,
  input wire logic        stop_request,
  input wire logic        watchdog_enable,
  input wire logic        watchdog_timeout_select,
  input wire logic        stop_mode_enable,
  input wire logic        stop_enter,
  input wire logic        illegal_opcode_reset,
  input wire logic        debug_pin_enable,
  input wire logic        reset_pin_enable,
  input wire logic        reset_pin_pullup
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Address phase of a write to the options word
  wire opt_hit = hsel && hready && htrans[1] && hwrite && (haddr[7:0] == 8'h00);
  // Address phase of any read
  wire rd_hit = hsel && hready && htrans[1] && !hwrite;
  sequence s_rd_taken;
    rd_hit;
  endsequence
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait; s_rd_taken |=> s_rd_wait; endproperty
  sequence s_stop_bad;
    stop_request && !stop_mode_enable;
  endsequence
  property p_ilop; s_stop_bad |=> illegal_opcode_reset; endproperty
  property p_ilop_cause; illegal_opcode_reset |-> $past(stop_request && !stop_mode_enable);
  endproperty
  property p_stop; stop_enter == (stop_request && stop_mode_enable); endproperty
  property p_pull; reset_pin_pullup == reset_pin_enable; endproperty
  property p_rst_keep; reset_pin_enable |=> reset_pin_enable; endproperty
  property p_dbg_set; !debug_pin_enable |=> !debug_pin_enable; endproperty
  property p_dbg_rst; $rose(hresetn) |=>
    debug_pin_enable == (!mode_select_pin || security_disengaged || power_on_reset);
  endproperty
  property p_opt_chg;
    $changed({watchdog_enable, watchdog_timeout_select, stop_mode_enable, reset_pin_enable})
      |-> $past(opt_hit, 2);
  endproperty
  property p_okay; !hresp && (hreadyout == !$past(rd_hit)); endproperty
  a_ilop: assert property (p_ilop) else $error("illegal reset missing");
  a_ilop_cause: assert property (p_ilop_cause) else $error("illegal reset uncaused");
  a_stop: assert property (p_stop) else $error("stop entry wrong");
  a_pull: assert property (p_pull) else $error("pullup differs");
  a_rst_keep: assert property (p_rst_keep) else $error("reset pin lost");
  a_dbg_set: assert property (p_dbg_set) else $error("debug pin set");
  a_dbg_rst: assert property (p_dbg_rst) else $error("debug pin reset value");
  a_opt_chg: assert property (p_opt_chg) else $error("options changed unasked");
  a_okay: assert property (p_okay) else $error("bus answer wrong");
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
endmodule
bind system_options_system_ctrl system_options_system_ctrl_sva system_options_system_ctrl_sva_inst (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .power_on_reset,
  .mode_select_pin, .security_disengaged, .stop_request, .watchdog_enable,
  .watchdog_timeout_select, .stop_mode_enable, .stop_enter, .illegal_opcode_reset,
  .debug_pin_enable, .reset_pin_enable, .reset_pin_pullup);
`default_nettype wire

//--- bench/test_system_options_system_ctrl.sv
/*
 Self-checking bench for the system control block.
 Assumes the slave may insert wait states; read data is taken at the edge
 where hready is sampled high in the data phase.
*/
`timescale 1ns/1ps
`default_nettype none
`include "system_options_map.vh"
module test_system_options_system_ctrl;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, stop_request = 0;
  logic        tick_1khz = 0, tick_32khz = 0, power_on_reset = 1;
  logic        mode_select_pin = 1, security_disengaged = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, v, e;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, watchdog_enable, watchdog_timeout_select;
  wire         stop_mode_enable, stop_enter, illegal_opcode_reset, debug_pin_enable;
  wire         reset_pin_enable, reset_pin_pullup, wakeup_irq, irq;
  wire         hready = hreadyout;
  wire  [5:0]  opt_out = {watchdog_enable, watchdog_timeout_select, stop_mode_enable,
                          debug_pin_enable, reset_pin_enable, reset_pin_pullup};
  int          error_cnt = 0, checked = 0, seed = 32'h28d9f56a;
  localparam logic [11:0] pn = `SYSTEM_OPTIONS_PART_NUMBER;

  // Clock of 10 ns
  always #5 hclk = ~hclk;

  system_options_system_ctrl system_options_system_ctrl_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .power_on_reset, .mode_select_pin,
    .security_disengaged, .stop_request, .tick_1khz, .tick_32khz, .watchdog_enable,
    .watchdog_timeout_select, .stop_mode_enable, .stop_enter, .illegal_opcode_reset,
    .debug_pin_enable, .reset_pin_enable, .reset_pin_pullup, .wakeup_irq, .irq);

  // Compare and count
  task automatic chk(logic [31:0] s, logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  // One single AHB-Lite transfer; settles one step past the last edge
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    #1;
  endtask

  task automatic rdc(logic [31:0] a, logic [31:0] m, logic [31:0] x);
    bus(0, a, 0);
    chk(rd & m, x);
  endtask

  // Tick pulses on the slow or the fast source
  task automatic tick(int n, logic f);
    repeat (n)
    begin
      @(posedge hclk);
      tick_1khz <= !f;
      tick_32khz <= f;
      @(posedge hclk);
      tick_1khz <= 0;
      tick_32khz <= 0;
    end
  endtask

  // Reset with one of four strap settings
  task automatic rst(int i);
    @(posedge hclk);
    hresetn <= 0;
    mode_select_pin <= (i != 1);
    security_disengaged <= (i == 2);
    power_on_reset <= (i == 3);
    repeat (20) @(posedge hclk);
    hresetn <= 1;
  endtask

  // Wakeup period in ticks for a nonzero code
  function automatic int per(logic [2:0] c);
    return (c == 3'h1) ? 8 : (1 << (c + 3));
  endfunction

  // Run one period, check flag edge, acknowledge
  task automatic wk(logic [2:0] c, logic f);
    e = {26'h0, f, 2'b10, c};
    bus(1, 32'hc, 0);
    bus(1, 32'hc, e);
    tick(per(c) * (f ? 32 : 1) - 1, f);
    rdc(32'hc, 32'hc0, 0);
    tick(1, f);
    rdc(32'hc, 32'hc0, 32'h80);
    chk(wakeup_irq, 1);
    bus(1, 32'hc, e | 32'h40);
    rdc(32'hc, 32'h80, 0);
    chk(wakeup_irq, 0);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      rst(i);
      rdc(0, 32'he3, (i != 0) ? 32'hc2 : 32'hc0);
    end
    $display("strap test done");
    rdc(4, 32'hffffffff, {24'h0, `SYSTEM_OPTIONS_REVISION, pn[11:8]});
    rdc(8, 32'hffffffff, {24'h0, pn[7:0]});
    rdc(32'h40, 32'hffffffff, 0);
    v = $random(seed);
    e = {24'h0, v[7:5], 3'h0, v[1:0]};
    bus(1, 0, v);
    rdc(0, 32'he3, e);
    chk(opt_out, {v[7:5], v[1:0], v[0]});
    bus(1, 0, ~v);
    rdc(0, 32'he3, e);
    rdc(32'h10, 32'h2, 32'h2);
    bus(1, 32'h14, 32'h3);
    chk(irq, 1);
    bus(1, 32'h18, 32'h2);
    chk(irq, 0);
    @(posedge hclk);
    stop_request <= 1;
    #1 chk(stop_enter, v[5]);
    @(posedge hclk);
    stop_request <= 0;
    #1 chk(illegal_opcode_reset, !v[5]);
    $display("options test done");
    for (int c = 1; c < 8; c++)
      wk(c[2:0], 0);
    wk(3'h1, 1);
    bus(1, 32'hc, 32'h10);
    tick(16, 0);
    rdc(32'hc, 32'h80, 0);
    $display("wakeup test done");
    report_and_stop();
  end

  // Hang guard
  initial
  begin
    #1_000_000;
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
